// ---- shared/mas_pkg.sv ----
// Shared constants and types for the microcode address sequencer.
package mas_pkg;

	// Address and word geometry of the microprogram store.
	localparam int MAS_AW    = 6;
	localparam int MAS_DW    = 32;
	localparam int MAS_WORDS = 64;
	localparam int MAS_TW    = 6;
	localparam int MAS_CW    = 16;

	// Microinstruction field positions, upper half of the word.
	localparam int MAS_OP_HI  = 31;
	localparam int MAS_OP_LO  = 28;
	localparam int MAS_K_HI   = 27;
	localparam int MAS_K_LO   = 22;
	localparam int MAS_SEL_HI = 26;
	localparam int MAS_SEL_LO = 24;
	localparam int MAS_POL    = 23;
	localparam int MAS_OE     = 22;
	localparam int MAS_D_HI   = 21;
	localparam int MAS_D_LO   = 16;

	// Control output split and the two repurposed diagnostic pins.
	localparam int MAS_LO_BYTE_HI = 7;
	localparam int MAS_DIAG_SHIFT_CLOCK_BIT   = 6;
	localparam int MAS_MODE_BIT   = 7;

	// Test selector codes beyond the six test inputs.
	localparam logic [2:0] MAS_SEL_CC    = 3'h6;
	localparam logic [2:0] MAS_SEL_MATCH = 3'h7;

	// Values after reset.
	localparam logic [5:0]  MAS_PC_RST   = 6'h3F;
	localparam logic [5:0]  MAS_CNT_RST  = 6'h00;
	localparam logic [5:0]  MAS_SUB_RST  = 6'h00;
	localparam logic [31:0] MAS_PIPE_RST = 32'h0000_0000;
	localparam logic [31:0] MAS_SHD_RST  = 32'h0000_0000;
	localparam logic [5:0]  MAS_ZERO6    = 6'h00;
	localparam logic [5:0]  MAS_ONE6     = 6'h01;

	// Microinstruction operations.
	typedef enum logic [3:0] {
		MAS_OP_CONT,
		MAS_OP_JMP,
		MAS_OP_JMP_MASK,
		MAS_OP_JCOND,
		MAS_OP_JCOND_MASK,
		MAS_OP_WAIT,
		MAS_OP_CALL,
		MAS_OP_CALL2,
		MAS_OP_RET,
		MAS_OP_LDCNT_K,
		MAS_OP_LDCNT_BR,
		MAS_OP_LDCNT_SUB,
		MAS_OP_LOOP,
		MAS_OP_REPEAT,
		MAS_OP_CMP
	} mas_op_t;

	// Next address sources.
	typedef enum logic [1:0] {MAS_SRC_PC, MAS_SRC_INC, MAS_SRC_BR, MAS_SRC_SUB} mas_src_t;

	// Count register load sources.
	typedef enum logic [2:0] {
		MAS_CNT_HOLD, MAS_CNT_DEC, MAS_CNT_FIELD, MAS_CNT_SUB, MAS_CNT_BR
	} mas_cnt_t;

	// Subroutine register load sources.
	typedef enum logic [1:0] {MAS_SUB_HOLD, MAS_SUB_CNT, MAS_SUB_INC} mas_sub_t;

endpackage

// ---- core/mas_prom.sv ----
// Flip-flop microprogram store with a fetch port and a program port.
`timescale 1ns/1ns
module mas_prom (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [5:0]  prog_addr_i,
	input  wire logic [31:0] prog_wdata_i,
	input  wire logic        prog_we_i,
	input  wire logic        prog_re_i,
	output logic      [31:0] prog_rdata_o,
	input  wire logic [5:0]  fetch_addr_i,
	output logic      [31:0] fetch_data_o
);

	logic [31:0] mem_r [mas_pkg::MAS_WORDS];
	logic [31:0] rdata_r;

	////////////////////////////////////////////////////////////////////////
	// One word per entry; contents survive reset like a fused array would.
	for (genvar gi = 0; gi < mas_pkg::MAS_WORDS; gi++) begin : g_word
		always_ff @(posedge clk_i) begin
			if (prog_we_i && prog_addr_i == 6'(gi)) begin
				mem_r[gi] <= prog_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data stand for exactly one cycle after the read strobe.
	always_ff @(posedge clk_i) begin
		if (rst_i || !prog_re_i) begin
			rdata_r <= mas_pkg::MAS_PIPE_RST;
		end else begin
			rdata_r <= mem_r[prog_addr_i];
		end
	end

	// Fetch is combinational so the pipeline catches it on the next edge.
	assign fetch_data_o = mem_r[fetch_addr_i];
	assign prog_rdata_o = rdata_r;

endmodule

// ---- core/mas_sequencer.sv ----
// Microcode address sequencer with pipeline and diagnostic shadow register.
//
// Operation
// - Six-bit address picked from four sources.
// - Selecting the counter re-executes current word.
// - Incremented counter is the default next address.
// - Jumps and passing branches use branch value.
// - Returns take the subroutine register as address.
// - Subroutine register loads hold, count or increment.
// - Count and return registers nest each other.
// - Loops decrement count; zero detect ends them.
// - Count loads decrement, field, subroutine, branch value.
// - Branch value is field or masked tests.
// - Branch value serves as target and count.
// - Compare sets match on equality, else holds.
// - Eight tests: six inputs, condition, match.
// - Polarity bit inverts the selected test.
// - Sixty-four by thirty-two bit program store.
// - Pipeline holds the executing word meanwhile fetching.
// - Low sixteen bits leave as control outputs.
// - Upper control byte floats when enable bit clear.
// - Shadow captures pipeline or shifts serial input.
// - Shadow loads pipeline, shifts out, or holds.
// - Shadow option takes over four pins.
`timescale 1ns/1ns
module mas_sequencer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [5:0]  test_i,
	input  wire logic        cond_i,
	input  wire logic        shadow_en_i,
	input  wire logic [1:0]  ctrl_in_i,
	output logic      [15:0] ctrl_o,
	output logic      [15:0] ctrl_oe_o,
	output logic             zero_o,
	output logic      [5:0]  uaddr_o,
	input  wire logic [5:0]  prog_addr_i,
	input  wire logic [31:0] prog_wdata_i,
	input  wire logic        prog_we_i,
	input  wire logic        prog_re_i,
	output logic      [31:0] prog_rdata_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic [5:0]  test_s1_r;
	logic [5:0]  test_s2_r;
	logic        cond_s1_r;
	logic        cond_s2_r;
	logic [1:0]  pin_s1_r;
	logic [1:0]  pin_s2_r;
	logic        diag_shift_clock_d_r;
	logic        shd_en_s1_r;
	logic        shd_en_s2_r;

	logic [5:0]  pc_r;
	logic [5:0]  cnt_r;
	logic [5:0]  sub_r;
	logic        match_r;
	logic [31:0] pipe_r;
	logic [31:0] shadow_r;
	logic        zero_pin_r;
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_oe_r;

	logic [5:0]  pc_nxt;
	logic [5:0]  cnt_nxt;
	logic [5:0]  sub_nxt;
	logic [31:0] pipe_nxt;
	logic [31:0] shadow_nxt;
	logic [31:0] fetch_word;

	logic [5:0]  inc_val;
	logic [5:0]  dec_val;
	logic [5:0]  field_d;
	logic [5:0]  field_k;
	logic [5:0]  masked;
	logic [5:0]  br_val;
	logic        cnt_zero;
	logic        cond_pin;
	logic        diag_serial_in;
	logic        diag_shift_clock;
	logic        diag_mode;
	logic        diag_shift_clock_rise;
	logic        shd_shift;
	logic        shd_capture;
	logic        shd_force;
	logic        test_raw;
	logic        test_ok;
	logic        match_set;

	mas_pkg::mas_op_t  op;
	mas_pkg::mas_src_t src_sel;
	mas_pkg::mas_cnt_t cnt_sel;
	mas_pkg::mas_sub_t sub_sel;

	////////////////////////////////////////////////////////////////////////
	// Program store.

	mas_prom u_prom (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.prog_addr_i  (prog_addr_i),
		.prog_wdata_i (prog_wdata_i),
		.prog_we_i    (prog_we_i),
		.prog_re_i    (prog_re_i),
		.prog_rdata_o (prog_rdata_o),
		.fetch_addr_i (pc_nxt),
		.fetch_data_o (fetch_word)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// Every pin passes two flops; the shift clock pin gets a third for its edge detect.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_s1_r <= mas_pkg::MAS_ZERO6;
			test_s2_r <= mas_pkg::MAS_ZERO6;
			cond_s1_r <= 1'b0;
			cond_s2_r <= 1'b0;
			pin_s1_r  <= 2'h0;
			pin_s2_r  <= 2'h0;
			diag_shift_clock_d_r  <= 1'b0;
		end else begin
			test_s1_r <= test_i;
			test_s2_r <= test_s1_r;
			cond_s1_r <= cond_i;
			cond_s2_r <= cond_s1_r;
			pin_s1_r  <= ctrl_in_i;
			pin_s2_r  <= pin_s1_r;
			diag_shift_clock_d_r  <= pin_s2_r[0];
		end
	end

	// The option fuse is a pin too; no reset, so it has settled before release.
	always_ff @(posedge clk_i) begin
		shd_en_s1_r <= shadow_en_i;
		shd_en_s2_r <= shd_en_s1_r;
	end

	assign diag_serial_in   = shd_en_s2_r & cond_s2_r;
	assign cond_pin         = ~shd_en_s2_r & cond_s2_r;
	assign diag_shift_clock = shd_en_s2_r & pin_s2_r[0];
	assign diag_mode        = shd_en_s2_r & pin_s2_r[1];

	// The shift clock is sampled, so it must run well below the system clock.
	assign diag_shift_clock_rise = diag_shift_clock & ~diag_shift_clock_d_r;

	////////////////////////////////////////////////////////////////////////
	// Shadow register operations.

	// Force, shift out, hold
	// With mode high the serial input line picks force or capture.
	assign shd_shift   = diag_shift_clock_rise & ~diag_mode;
	assign shd_capture = diag_shift_clock_rise & diag_mode & ~diag_serial_in;
	assign shd_force   = diag_shift_clock_rise & diag_mode & diag_serial_in;

	// Shadow next value; no shift clock edge means it holds.
	always_comb begin
		shadow_nxt = shadow_r;
		if (shd_shift) begin
			shadow_nxt = {shadow_r[30:0], diag_serial_in};
		end else if (shd_capture) begin
			shadow_nxt = pipe_r;
		end
	end

	// Shadow register state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shadow_r <= mas_pkg::MAS_SHD_RST;
		end else begin
			shadow_r <= shadow_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field decode and branch value.

	assign op      = mas_pkg::mas_op_t'(pipe_r[mas_pkg::MAS_OP_HI:mas_pkg::MAS_OP_LO]);
	assign field_d = pipe_r[mas_pkg::MAS_D_HI:mas_pkg::MAS_D_LO];
	assign field_k = pipe_r[mas_pkg::MAS_K_HI:mas_pkg::MAS_K_LO];
	assign inc_val = pc_r + mas_pkg::MAS_ONE6;
	assign dec_val = cnt_r - mas_pkg::MAS_ONE6;

	assign cnt_zero = (cnt_r == mas_pkg::MAS_ZERO6);

	assign masked = test_s2_r & field_d;

	// Masked or direct value
	// The masked-form jumps, and a branch count load with the polarity bit set, take the tests as the value.
	assign br_val = (op == mas_pkg::MAS_OP_JMP_MASK || op == mas_pkg::MAS_OP_JCOND_MASK ||
		op == mas_pkg::MAS_OP_LDCNT_BR && pipe_r[mas_pkg::MAS_POL]) ? masked : field_d;

	////////////////////////////////////////////////////////////////////////
	// Condition selection.

	always_comb begin
		case (pipe_r[mas_pkg::MAS_SEL_HI:mas_pkg::MAS_SEL_LO])
			mas_pkg::MAS_SEL_CC:    test_raw = cond_pin;
			mas_pkg::MAS_SEL_MATCH: test_raw = match_r;
			default:                test_raw = test_s2_r[pipe_r[mas_pkg::MAS_SEL_LO +: 3]];
		endcase
	end

	assign test_ok = test_raw ^ pipe_r[mas_pkg::MAS_POL];

	assign match_set = (op == mas_pkg::MAS_OP_CMP) && (masked == field_k);

	////////////////////////////////////////////////////////////////////////
	// Instruction decode.

	// Each operation chooses the address source and the two register loads.
	always_comb begin
		src_sel = mas_pkg::MAS_SRC_INC;
		cnt_sel = mas_pkg::MAS_CNT_HOLD;
		sub_sel = mas_pkg::MAS_SUB_HOLD;
		case (op)
			mas_pkg::MAS_OP_CONT: src_sel = mas_pkg::MAS_SRC_INC;
			mas_pkg::MAS_OP_JMP, mas_pkg::MAS_OP_JMP_MASK: src_sel = mas_pkg::MAS_SRC_BR;
			mas_pkg::MAS_OP_JCOND, mas_pkg::MAS_OP_JCOND_MASK: begin
				if (test_ok) begin
					src_sel = mas_pkg::MAS_SRC_BR;
				end
			end
			mas_pkg::MAS_OP_WAIT: begin
				if (!test_ok) begin
					src_sel = mas_pkg::MAS_SRC_PC;
				end
			end
			mas_pkg::MAS_OP_CALL: begin
				if (test_ok) begin
					src_sel = mas_pkg::MAS_SRC_BR;
					sub_sel = mas_pkg::MAS_SUB_INC;
				end
			end
			mas_pkg::MAS_OP_CALL2: begin
				if (test_ok) begin
					src_sel = mas_pkg::MAS_SRC_BR;
					sub_sel = mas_pkg::MAS_SUB_INC;
					cnt_sel = mas_pkg::MAS_CNT_SUB;
				end
			end
			mas_pkg::MAS_OP_RET: begin
				if (test_ok) begin
					src_sel = mas_pkg::MAS_SRC_SUB;
					sub_sel = mas_pkg::MAS_SUB_CNT;
				end
			end
			mas_pkg::MAS_OP_LDCNT_K: cnt_sel = mas_pkg::MAS_CNT_FIELD;
			mas_pkg::MAS_OP_LDCNT_BR: cnt_sel = mas_pkg::MAS_CNT_BR;
			// Loop count saved in subroutine register
			mas_pkg::MAS_OP_LDCNT_SUB: begin
				cnt_sel = mas_pkg::MAS_CNT_SUB;
				sub_sel = mas_pkg::MAS_SUB_CNT;
			end
			mas_pkg::MAS_OP_LOOP: begin
				if (!cnt_zero) begin
					src_sel = mas_pkg::MAS_SRC_BR;
					cnt_sel = mas_pkg::MAS_CNT_DEC;
				end
			end
			mas_pkg::MAS_OP_REPEAT: begin
				if (!cnt_zero) begin
					src_sel = mas_pkg::MAS_SRC_PC;
					cnt_sel = mas_pkg::MAS_CNT_DEC;
				end
			end
			mas_pkg::MAS_OP_CMP: src_sel = mas_pkg::MAS_SRC_INC;
			default: src_sel = mas_pkg::MAS_SRC_INC;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state selectors.

	always_comb begin
		case (src_sel)
			mas_pkg::MAS_SRC_PC:  pc_nxt = pc_r;
			mas_pkg::MAS_SRC_BR:  pc_nxt = br_val;
			mas_pkg::MAS_SRC_SUB: pc_nxt = sub_r;
			default:              pc_nxt = inc_val;
		endcase
	end

	always_comb begin
		case (cnt_sel)
			mas_pkg::MAS_CNT_DEC:   cnt_nxt = dec_val;
			mas_pkg::MAS_CNT_FIELD: cnt_nxt = field_k;
			mas_pkg::MAS_CNT_SUB:   cnt_nxt = sub_r;
			mas_pkg::MAS_CNT_BR:    cnt_nxt = br_val;
			default:                cnt_nxt = cnt_r;
		endcase
	end

	always_comb begin
		case (sub_sel)
			mas_pkg::MAS_SUB_CNT: sub_nxt = cnt_r;
			mas_pkg::MAS_SUB_INC: sub_nxt = inc_val;
			default:              sub_nxt = sub_r;
		endcase
	end

	// Force into pipeline
	// A forced word replaces the fetch and the address stays put for it.
	assign pipe_nxt = shd_force ? shadow_r : fetch_word;

	////////////////////////////////////////////////////////////////////////
	// Sequencer state, all on one edge.

	// Reset restarts at zero
	// The pipeline resets to a plain step from the last word, so the
	// first fetch after release is word zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_r   <= mas_pkg::MAS_PC_RST;
			pipe_r <= mas_pkg::MAS_PIPE_RST;
		end else begin
			pc_r   <= shd_force ? pc_r : pc_nxt;
			pipe_r <= pipe_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= mas_pkg::MAS_CNT_RST;
			sub_r <= mas_pkg::MAS_SUB_RST;
		end else begin
			cnt_r <= cnt_nxt;
			sub_r <= sub_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_r <= 1'b0;
		end else if (match_set) begin
			match_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output registers.

	// Zero pin carries serial out
	// Registered from next values so the pin tracks the state flops.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_pin_r <= 1'b1;
		end else if (shd_en_s2_r) begin
			zero_pin_r <= shadow_nxt[mas_pkg::MAS_DW - 1];
		end else begin
			zero_pin_r <= (cnt_nxt == mas_pkg::MAS_ZERO6);
		end
	end

	// Pins six and seven become inputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r    <= 16'h0000;
			ctrl_oe_r <= 16'h0000;
		end else begin
			ctrl_r <= pipe_nxt[mas_pkg::MAS_CW - 1:0];
			ctrl_oe_r[mas_pkg::MAS_CW - 1:mas_pkg::MAS_LO_BYTE_HI + 1] <=
				{8{pipe_nxt[mas_pkg::MAS_OE]}};
			ctrl_oe_r[mas_pkg::MAS_LO_BYTE_HI:0] <=
				shd_en_s2_r ? 8'h3F : 8'hFF;
		end
	end

	assign ctrl_o    = ctrl_r;
	assign ctrl_oe_o = ctrl_oe_r;
	assign zero_o    = zero_pin_r;
	assign uaddr_o   = pc_r;

endmodule

// ---- bench/mas_seq_sva.sv ----
// Port-level checker for the microcode address sequencer, bound at the file foot.
`timescale 1ns/1ns
module mas_seq_sva (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        shadow_en_i,
	input wire logic [1:0]  ctrl_in_i,
	input wire logic [15:0] ctrl_o,
	input wire logic [15:0] ctrl_oe_o,
	input wire logic        zero_o,
	input wire logic [5:0]  uaddr_o,
	input wire logic [5:0]  prog_addr_i,
	input wire logic [31:0] prog_wdata_i,
	input wire logic        prog_we_i,
	input wire logic        prog_re_i,
	input wire logic [31:0] prog_rdata_o
);
	logic [31:0] mem_r [64];
	logic        live_r;
	logic [31:0] cur_w;
	logic [5:0]  dat_w;
	logic [3:0]  op_w;
	logic        run_w;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// Mirror of the store, so each fetched word can be predicted.
	always_ff @(posedge clk_i) begin
		if (prog_we_i) begin
			mem_r[prog_addr_i] <= prog_wdata_i;
		end
	end
	// The first edge after reset still shows reset values, so it is skipped.
	always_ff @(posedge clk_i) begin
		live_r <= !rst_i;
	end
	// A forced shadow word is not in the store, so only normal mode is judged.
	assign cur_w = mem_r[uaddr_o];
	assign op_w  = cur_w[31:28];
	assign dat_w = cur_w[21:16];
	assign run_w = live_r && !shadow_en_i;
	sequence diag_quiet;
		(shadow_en_i && !rst_i && $stable(ctrl_in_i[0])) [*8];
	endsequence
	////////////////////////////////////////////////////////////////
	a_read_data: assert property (
		prog_re_i && !prog_we_i |=> prog_rdata_o == mem_r[$past(prog_addr_i)])
		else $error("read data differs from the store");
	a_read_idle: assert property (
		!prog_re_i |=> prog_rdata_o == 32'h0000_0000)
		else $error("read data not cleared");
	a_ctrl_word: assert property (
		run_w |-> ctrl_o == cur_w[15:0])
		else $error("control outputs differ from the word");
	a_upper_oe: assert property (
		run_w |-> ctrl_oe_o == {{8{cur_w[22]}}, 8'hFF})
		else $error("output enables wrong");
	a_shadow_pins: assert property (
		shadow_en_i && live_r |-> ctrl_oe_o[7:0] == 8'h3F)
		else $error("diagnostic pins still driven");
	a_step_inc: assert property (
		run_w && op_w == mas_pkg::MAS_OP_CONT |=> uaddr_o == $past(uaddr_o) + 6'h01)
		else $error("continue did not step");
	a_jump_tgt: assert property (
		run_w && op_w == mas_pkg::MAS_OP_JMP |=> uaddr_o == $past(dat_w))
		else $error("jump target wrong");
	a_reset_start: assert property (
		$fell(rst_i) |-> zero_o && ctrl_oe_o == 16'h0000 ##1 uaddr_o == 6'h00)
		else $error("start after reset wrong");
	a_shadow_hold: assert property (
		diag_quiet |=> $stable(zero_o))
		else $error("shadow moved without a diagnostic clock");
endmodule

bind mas_sequencer mas_seq_sva u_sva (
	.clk_i,
	.rst_i,
	.shadow_en_i,
	.ctrl_in_i,
	.ctrl_o,
	.ctrl_oe_o,
	.zero_o,
	.uaddr_o,
	.prog_addr_i,
	.prog_wdata_i,
	.prog_we_i,
	.prog_re_i,
	.prog_rdata_o
);

// ---- bench/mas_dp_model.sv ----
// Far-side datapath model: feeds the test pins and shares control pins 6 and 7.
`timescale 1ns/1ns
module mas_dp_model (
	input  wire logic [15:0] ctrl_o,
	input  wire logic [15:0] ctrl_oe_o,
	input  wire logic [5:0]  status_i,
	input  wire logic        diag_shift_clock_i,
	input  wire logic        dmode_i,
	output logic      [5:0]  test_o,
	output logic      [1:0]  pin_o
);
	// Datapath status flags are what the sequencer tests.
	assign test_o = status_i;
	// shared diagnostic pins
	// The sequencer wins while it drives; otherwise the diagnostic drive shows.
	assign pin_o[0] = ctrl_oe_o[6] ? ctrl_o[6] : diag_shift_clock_i;
	assign pin_o[1] = ctrl_oe_o[7] ? ctrl_o[7] : dmode_i;
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the microcode address sequencer.
`timescale 1ns/1ns
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cond_i = 1'b0;
	logic        shadow_en_i = 1'b0;
	logic        diag_shift_clock_v = 1'b0;
	logic        dmode_v = 1'b0;
	logic [5:0]  status_v = 6'h00;
	logic [5:0]  prog_addr_i = 6'h00;
	logic [31:0] prog_wdata_i = 32'h0000_0000;
	logic        prog_we_i = 1'b0;
	logic        prog_re_i = 1'b0;
	logic [5:0]  test_i;
	logic [1:0]  ctrl_in_i;
	logic [15:0] ctrl_o;
	logic [15:0] ctrl_oe_o;
	logic        zero_o;
	logic [5:0]  uaddr_o;
	logic [31:0] prog_rdata_o;
	logic [31:0] img [int];
	logic [31:0] w44;
	int          bad_count = 0;
	int          num_checks = 0;
	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	// Design and the datapath that sits on its control pins.
	mas_sequencer dut (
		.clk_i,
		.rst_i,
		.test_i,
		.cond_i,
		.shadow_en_i,
		.ctrl_in_i,
		.ctrl_o,
		.ctrl_oe_o,
		.zero_o,
		.uaddr_o,
		.prog_addr_i,
		.prog_wdata_i,
		.prog_we_i,
		.prog_re_i,
		.prog_rdata_o
	);
	mas_dp_model u_dp (
		.ctrl_o,
		.ctrl_oe_o,
		.status_i(status_v),
		.diag_shift_clock_i(diag_shift_clock_v),
		.dmode_i(dmode_v),
		.test_o(test_i),
		.pin_o(ctrl_in_i)
	);
	////////////////////////////////////////////////////////////////
	// Word layout: op, constant or select field, data field, control bits.
	function automatic logic [31:0] mk(input logic [3:0] op, input logic [5:0] k,
		input logic [5:0] d, input logic [15:0] c);
		return {op, k, d, c};
	endfunction
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] w);
		@(posedge clk_i);
		prog_addr_i <= a;
		prog_wdata_i <= w;
		prog_we_i <= 1'b1;
		@(posedge clk_i);
		prog_we_i <= 1'b0;
	endtask
	// The store is not cleared by reset, so the image goes in while it is held.
	task automatic boot();
		@(posedge clk_i);
		rst_i <= 1'b1;
		foreach (img[a]) begin
			wr(a[5:0], img[a]);
		end
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// Pins pass a two-stage synchroniser, so each phase is held several cycles.
	task automatic pulse(input logic m, input logic s);
		@(posedge clk_i);
		dmode_v <= m;
		cond_i <= s;
		repeat (4) @(posedge clk_i);
		diag_shift_clock_v <= 1'b1;
		repeat (6) @(posedge clk_i);
		diag_shift_clock_v <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_seq();
		logic [5:0] exp_q [$] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h05, 6'h05, 6'h06,
			6'h0A, 6'h07, 6'h08, 6'h0C, 6'h0D, 6'h10, 6'h2C, 6'h2C, 6'h2C};
		img.delete();
		img[0] = mk(mas_pkg::MAS_OP_CONT, 6'h01, 6'h00, 16'hA5C3);
		img[1] = mk(mas_pkg::MAS_OP_JMP, 6'h00, 6'h04, 16'h0000);
		img[4] = mk(mas_pkg::MAS_OP_LDCNT_K, 6'h02, 6'h00, 16'h0000);
		img[5] = mk(mas_pkg::MAS_OP_REPEAT, 6'h00, 6'h00, 16'h0000);
		img[6] = mk(mas_pkg::MAS_OP_CALL, 6'h1B, 6'h0A, 16'h0000);
		img[10] = mk(mas_pkg::MAS_OP_RET, 6'h02, 6'h00, 16'h0000);
		img[7] = mk(mas_pkg::MAS_OP_JCOND, 6'h01, 6'h14, 16'h0000);
		img[8] = mk(mas_pkg::MAS_OP_JCOND, 6'h03, 6'h0C, 16'h0000);
		img[12] = mk(mas_pkg::MAS_OP_CMP, 6'h0C, 6'h0F, 16'h0000);
		img[13] = mk(mas_pkg::MAS_OP_JCOND, 6'h1D, 6'h10, 16'h0000);
		img[16] = mk(mas_pkg::MAS_OP_JMP_MASK, 6'h00, 6'h3C, 16'h0000);
		img[44] = w44;
		status_v <= 6'h2C;
		cond_i <= 1'b0;
		boot();
		foreach (exp_q[i]) begin
			@(posedge clk_i);
			#1;
			chk(uaddr_o === exp_q[i], "next address");
		end
		chk(ctrl_o === 16'h5A3C && ctrl_oe_o === 16'h00FF, "control pins");
		$display("t_seq done");
	endtask
	// Back-to-back reads; each answer stands for exactly one cycle.
	task automatic t_prog();
		wr(6'h3E, 32'h5A5A_0F0F);
		wr(6'h3F, 32'h0123_ABCD);
		@(posedge clk_i);
		prog_addr_i <= 6'h3E;
		prog_re_i <= 1'b1;
		@(posedge clk_i);
		prog_addr_i <= 6'h3F;
		#1;
		chk(prog_rdata_o === 32'h5A5A_0F0F, "first read");
		@(posedge clk_i);
		prog_re_i <= 1'b0;
		#1;
		chk(prog_rdata_o === 32'h0123_ABCD, "second read");
		@(posedge clk_i);
		#1;
		chk(prog_rdata_o === 32'h0000_0000, "read data cleared");
		$display("t_prog done");
	endtask
	// One loop level, two call levels, a masked count load and a count swap.
	task automatic t_nest();
		logic [5:0] exp_q [$] = '{6'h00, 6'h01, 6'h02, 6'h01, 6'h02, 6'h01, 6'h02, 6'h03,
			6'h08, 6'h0C, 6'h09, 6'h04, 6'h05, 6'h06, 6'h2C, 6'h2C};
		logic [15:0] zmask = 16'h01E1;
		img.delete();
		img[0] = mk(mas_pkg::MAS_OP_LDCNT_K, 6'h02, 6'h00, 16'h0000);
		img[1] = mk(mas_pkg::MAS_OP_CONT, 6'h00, 6'h00, 16'h0000);
		img[2] = mk(mas_pkg::MAS_OP_LOOP, 6'h00, 6'h01, 16'h0000);
		img[3] = mk(mas_pkg::MAS_OP_CALL, 6'h02, 6'h08, 16'h0000);
		img[4] = mk(mas_pkg::MAS_OP_LDCNT_BR, 6'h02, 6'h3F, 16'h0000);
		img[5] = mk(mas_pkg::MAS_OP_LDCNT_SUB, 6'h00, 6'h00, 16'h0000);
		img[6] = mk(mas_pkg::MAS_OP_RET, 6'h02, 6'h00, 16'h0000);
		img[8] = mk(mas_pkg::MAS_OP_CALL2, 6'h02, 6'h0C, 16'h0000);
		img[9] = mk(mas_pkg::MAS_OP_RET, 6'h02, 6'h00, 16'h0000);
		img[12] = mk(mas_pkg::MAS_OP_RET, 6'h02, 6'h00, 16'h0000);
		img[44] = w44;
		boot();
		foreach (exp_q[i]) begin
			@(posedge clk_i);
			#1;
			chk(uaddr_o === exp_q[i], "nested address");
			chk(zero_o === zmask[i], "count zero pin");
		end
		$display("t_nest done");
	endtask
	// Shift a jump in, force it, capture the result and shift it out.
	task automatic t_shadow();
		logic [31:0] jw;
		jw = mk(mas_pkg::MAS_OP_JMP, 6'h00, 6'h2C, 16'h0000);
		// The option fuse only changes while reset is held.
		@(posedge clk_i);
		rst_i <= 1'b1;
		shadow_en_i <= 1'b1;
		img.delete();
		img[0] = w44;
		boot();
		repeat (4) @(posedge clk_i);
		#1;
		chk(uaddr_o === 6'h00, "waiting before force");
		for (int i = 31; i >= 0; i--) begin
			pulse(1'b0, jw[i]);
		end
		pulse(1'b1, 1'b1);
		chk(uaddr_o === 6'h2C, "forced word executed");
		pulse(1'b1, 1'b0);
		for (int i = 31; i >= 0; i--) begin
			chk(zero_o === w44[i], "serial out bit");
			pulse(1'b0, 1'b0);
		end
		$display("t_shadow done");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		w44 = mk(mas_pkg::MAS_OP_WAIT, 6'h04, 6'h00, 16'h5A3C);
		t_seq();
		t_prog();
		t_nest();
		t_shadow();
		report_and_stop();
	end
	// Whole run is near 1100 cycles; this limit leaves ample slack.
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule
